/* File: hw/sbmv_params.svh */
`ifndef SBMV_PARAMS_SVH
`define SBMV_PARAMS_SVH
`define SBMV_ADDR_W 16
`define SBMV_OFS_P1_VLAN 16'h1C14
`define SBMV_OFS_P2_VLAN 16'h1C15
`define SBMV_OFS_P0_DROP 16'h1C16
`define SBMV_OFS_P1_DROP 16'h1C17
`define SBMV_OFS_P2_DROP 16'h1C18
`define SBMV_OFS_IRQ_MASK 16'h1C20
`define SBMV_PRIO_HI 14
`define SBMV_PRIO_LO 12
`define SBMV_VID_HI 11
`define SBMV_VID_LO 0
`define SBMV_PRIO_RST 3'h0
`define SBMV_VID_RST 12'h001
`define SBMV_CNT_RST 32'h00000000
`define SBMV_CNT_MAX 32'hFFFFFFFF
`define SBMV_MASK_BIT 0
`define SBMV_MASK_RST 1'h1
`define SBMV_NPORT 3
`endif

/* File: hw/sbmv_pkg.sv */
package sbmv_pkg;
    typedef logic [31:0] sbmv_word_t;
    typedef struct packed {
        logic [2:0] prio1;
        logic [11:0] vid1;
        logic [2:0] prio2;
        logic [11:0] vid2;
        logic mask;
        logic irq;
        logic [31:0] rdata;
        logic rvalid;
    } sbmv_regs_s;
endpackage

/* File: hw/sbmv_drop_counter.sv */
`timescale 1ns/1ps
`include "sbmv_params.svh"

// Saturating drop counter with clear on read; a drop in the read cycle is kept
module sbmv_drop_counter (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic drop_i,
    input wire logic rd_clr_i,
    output logic [31:0] count_o
);
    typedef struct packed {
        logic [31:0] cnt;
    } sbmv_cnt_s;

    sbmv_cnt_s st_r;
    sbmv_cnt_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (rd_clr_i) begin
            // Read returns the old value; a drop landing now counts as one
            st_nxt.cnt = drop_i ? 32'h00000001 : `SBMV_CNT_RST;
        end else if (drop_i && st_r.cnt != `SBMV_CNT_MAX) begin
            st_nxt.cnt = st_r.cnt + 32'h00000001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_r.cnt <= `SBMV_CNT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_o = st_r.cnt;

    // The all-ones stop is out of reach of any short run, so the no-wrap check watches every step without a clearing read
    a_cnt_saturate: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (st_r.cnt == `SBMV_CNT_MAX && !rd_clr_i) |=> st_r.cnt == `SBMV_CNT_MAX)
        else $error("drop counter wrapped");
    a_cnt_no_wrap: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !rd_clr_i |=> st_r.cnt >= $past(st_r.cnt))
        else $error("drop counter went down without a read");
    a_cnt_increment: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (drop_i && !rd_clr_i && st_r.cnt != `SBMV_CNT_MAX) |=> st_r.cnt == $past(st_r.cnt) + 32'h00000001)
        else $error("drop not counted");
    a_cnt_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (rd_clr_i && !drop_i) |=> st_r.cnt == `SBMV_CNT_RST)
        else $error("read did not clear counter");
    a_cnt_clear_drop: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (rd_clr_i && drop_i) |=> st_r.cnt == 32'h00000001)
        else $error("drop during clearing read lost");
endmodule

/* File: hw/sbmv_regs.sv */
`timescale 1ns/1ps
`include "sbmv_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Ports 1 and 2 hold 3-bit default priority in bits 14:12, reset zero.
// - Ports 1 and 2 hold 12-bit default VLAN ID in bits 11:0, reset one.
// - Each port counts packets dropped by ingress rate limiting, red or yellow.
// - Drop counters reset to zero; a read returns count then clears it.
// - Drop counters stop at all ones instead of wrapping.
// - Mask bit 0 suppresses all buffer manager interrupts while set.
// - Masking only gates the output; pending status keeps recording.
// - Mask bit resets to one, so interrupts start masked.
// - Pending status is double buffered and every interrupt obeys the mask.
module sbmv_regs (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [2:0] rate_drop_i,
    input wire logic [13:0] buffer_irq_pending_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic [2:0] port1_default_prio_o,
    output logic [11:0] port1_default_vid_o,
    output logic [2:0] port2_default_prio_o,
    output logic [11:0] port2_default_vid_o,
    output logic buffer_irq_mask_o,
    output logic buffer_irq_o
);
    sbmv_pkg::sbmv_regs_s st_r;
    sbmv_pkg::sbmv_regs_s st_nxt;
    logic [31:0] cnt [0:`SBMV_NPORT-1];
    logic [`SBMV_NPORT-1:0] rd_clr;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [31:0] vlan_word(input logic [2:0] p, input logic [11:0] v);
        vlan_word = 32'h00000000;
        vlan_word[`SBMV_PRIO_HI:`SBMV_PRIO_LO] = p;
        vlan_word[`SBMV_VID_HI:`SBMV_VID_LO] = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < `SBMV_NPORT; gi = gi + 1) begin : g_cnt
            // Counter offsets run on from port 0; only a real read clears, writes are ignored
            assign rd_clr[gi] = reg_rd_i && hit(reg_addr_i, `SBMV_OFS_P0_DROP + 16'(gi));
            sbmv_drop_counter u_cnt (
                .core_clk_i(core_clk_i),
                .srst_i(srst_i),
                .drop_i(rate_drop_i[gi]),
                .rd_clr_i(rd_clr[gi]),
                .count_o(cnt[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = reg_rd_i;
        st_nxt.rdata = 32'h00000000;
        if (reg_wr_i) begin
            if (hit(reg_addr_i, `SBMV_OFS_P1_VLAN)) begin
                st_nxt.prio1 = reg_wdata_i[`SBMV_PRIO_HI:`SBMV_PRIO_LO];
                st_nxt.vid1 = reg_wdata_i[`SBMV_VID_HI:`SBMV_VID_LO];
            end
            if (hit(reg_addr_i, `SBMV_OFS_P2_VLAN)) begin
                st_nxt.prio2 = reg_wdata_i[`SBMV_PRIO_HI:`SBMV_PRIO_LO];
                st_nxt.vid2 = reg_wdata_i[`SBMV_VID_HI:`SBMV_VID_LO];
            end
            if (hit(reg_addr_i, `SBMV_OFS_IRQ_MASK)) begin
                st_nxt.mask = reg_wdata_i[`SBMV_MASK_BIT];
            end
        end
        if (reg_rd_i) begin
            // Unmapped and reserved bits read as zero
            unique case (reg_addr_i)
                `SBMV_OFS_P1_VLAN: st_nxt.rdata = vlan_word(st_r.prio1, st_r.vid1);
                `SBMV_OFS_P2_VLAN: st_nxt.rdata = vlan_word(st_r.prio2, st_r.vid2);
                `SBMV_OFS_P0_DROP: st_nxt.rdata = cnt[0];
                `SBMV_OFS_P1_DROP: st_nxt.rdata = cnt[1];
                `SBMV_OFS_P2_DROP: st_nxt.rdata = cnt[2];
                `SBMV_OFS_IRQ_MASK: st_nxt.rdata = {31'h00000000, st_r.mask};
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end
        // Pending status is owned and double buffered upstream; only gated here
        st_nxt.irq = (|buffer_irq_pending_i) && !st_nxt.mask;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_r.prio1 <= `SBMV_PRIO_RST;
            st_r.vid1 <= `SBMV_VID_RST;
            st_r.prio2 <= `SBMV_PRIO_RST;
            st_r.vid2 <= `SBMV_VID_RST;
            st_r.mask <= `SBMV_MASK_RST;
            st_r.irq <= 1'h0;
            st_r.rdata <= 32'h00000000;
            st_r.rvalid <= 1'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign reg_rvalid_o = st_r.rvalid;
    assign port1_default_prio_o = st_r.prio1;
    assign port1_default_vid_o = st_r.vid1;
    assign port2_default_prio_o = st_r.prio2;
    assign port2_default_vid_o = st_r.vid2;
    assign buffer_irq_mask_o = st_r.mask;
    assign buffer_irq_o = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields: reset values, writes, and holding between writes
    a_vid_reset: assert property (@(posedge core_clk_i)
        $fell(srst_i)
        |-> port1_default_vid_o == `SBMV_VID_RST && port2_default_vid_o == `SBMV_VID_RST)
        else $error("vid reset value wrong");
    a_prio_reset: assert property (@(posedge core_clk_i)
        $fell(srst_i)
        |-> port1_default_prio_o == `SBMV_PRIO_RST && port2_default_prio_o == `SBMV_PRIO_RST)
        else $error("priority reset value wrong");
    a_vid_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_wr_i && hit(reg_addr_i, `SBMV_OFS_P1_VLAN)
        |=> port1_default_vid_o == $past(reg_wdata_i[`SBMV_VID_HI:`SBMV_VID_LO]))
        else $error("port 1 vid write lost");
    a_vid2_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_wr_i && hit(reg_addr_i, `SBMV_OFS_P2_VLAN)
        |=> port2_default_vid_o == $past(reg_wdata_i[`SBMV_VID_HI:`SBMV_VID_LO]))
        else $error("port 2 vid write lost");
    a_prio_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_wr_i && hit(reg_addr_i, `SBMV_OFS_P2_VLAN)
        |=> port2_default_prio_o == $past(reg_wdata_i[`SBMV_PRIO_HI:`SBMV_PRIO_LO]))
        else $error("port 2 priority write lost");
    a_prio1_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_wr_i && hit(reg_addr_i, `SBMV_OFS_P1_VLAN)
        |=> port1_default_prio_o == $past(reg_wdata_i[`SBMV_PRIO_HI:`SBMV_PRIO_LO]))
        else $error("port 1 priority write lost");
    a_vlan1_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !(reg_wr_i && hit(reg_addr_i, `SBMV_OFS_P1_VLAN))
        |=> $stable({port1_default_prio_o, port1_default_vid_o}))
        else $error("port 1 defaults changed without a write");
    a_vlan2_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !(reg_wr_i && hit(reg_addr_i, `SBMV_OFS_P2_VLAN))
        |=> $stable({port2_default_prio_o, port2_default_vid_o}))
        else $error("port 2 defaults changed without a write");

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt gating; mask and request register on the same edge, so they never disagree
    a_mask_reset: assert property (@(posedge core_clk_i)
        $fell(srst_i)
        |-> st_r.mask == `SBMV_MASK_RST)
        else $error("mask not set after reset");
    a_mask_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_wr_i && hit(reg_addr_i, `SBMV_OFS_IRQ_MASK)
        |=> st_r.mask == $past(reg_wdata_i[`SBMV_MASK_BIT]))
        else $error("mask write not stored");
    a_mask_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !(reg_wr_i && hit(reg_addr_i, `SBMV_OFS_IRQ_MASK))
        |=> $stable(buffer_irq_mask_o))
        else $error("mask changed without a write");
    a_mask_gates_irq: assert property (@(posedge core_clk_i) disable iff (srst_i)
        st_r.mask
        |-> !buffer_irq_o)
        else $error("interrupt while masked");
    a_irq_follows: assert property (@(posedge core_clk_i) disable iff (srst_i)
        |buffer_irq_pending_i && !st_nxt.mask
        |=> buffer_irq_o)
        else $error("interrupt missing when unmasked");
    a_irq_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !(|buffer_irq_pending_i && !st_nxt.mask)
        |=> !buffer_irq_o)
        else $error("interrupt raised without cause");
    a_irq_cause: assert property (@(posedge core_clk_i) disable iff (srst_i)
        buffer_irq_o
        |-> $past(|buffer_irq_pending_i))
        else $error("interrupt without pending status");

    ////////////////////////////////////////////////////////////////////////////
    // Read answers come one cycle after the strobe and stand for that cycle only
    a_cnt0_readback: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_rd_i && hit(reg_addr_i, `SBMV_OFS_P0_DROP)
        |=> reg_rvalid_o && reg_rdata_o == $past(cnt[0]))
        else $error("port 0 counter read returned wrong value");
    a_cnt_readback: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_rd_i && hit(reg_addr_i, `SBMV_OFS_P1_DROP)
        |=> reg_rvalid_o && reg_rdata_o == $past(cnt[1]))
        else $error("counter read returned wrong value");
    a_cnt2_readback: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_rd_i && hit(reg_addr_i, `SBMV_OFS_P2_DROP)
        |=> reg_rvalid_o && reg_rdata_o == $past(cnt[2]))
        else $error("port 2 counter read returned wrong value");
    a_vlan1_readback: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_rd_i && hit(reg_addr_i, `SBMV_OFS_P1_VLAN)
        |=> reg_rdata_o == 32'({$past(port1_default_prio_o), $past(port1_default_vid_o)}))
        else $error("port 1 defaults read back wrong");
    a_vlan2_readback: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_rd_i && hit(reg_addr_i, `SBMV_OFS_P2_VLAN)
        |=> reg_rdata_o == 32'({$past(port2_default_prio_o), $past(port2_default_vid_o)}))
        else $error("port 2 defaults read back wrong");
    a_mask_readback: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_rd_i && hit(reg_addr_i, `SBMV_OFS_IRQ_MASK)
        |=> reg_rdata_o == 32'($past(buffer_irq_mask_o)))
        else $error("mask read back wrong");
    a_rvalid_pulse: assert property (@(posedge core_clk_i) disable iff (srst_i)
        reg_rd_i
        |=> reg_rvalid_o)
        else $error("read not answered");
    a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !reg_rd_i
        |=> !reg_rvalid_o && reg_rdata_o == 32'h00000000)
        else $error("read answer without a read");
endmodule

/* File: bench/sbmv_regs_tb.sv */
`timescale 1ns/1ps
`include "sbmv_params.svh"
module sbmv_regs_tb;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h00000000;
    logic [2:0] rate_drop_i = 3'h0;
    logic [13:0] buffer_irq_pending_i = 14'h0001;
    logic [31:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic [2:0] p1_prio;
    logic [11:0] p1_vid;
    logic [2:0] p2_prio;
    logic [11:0] p2_vid;
    logic mask_o;
    logic irq_o;
    int n_fail = 0;
    int tests_run = 0;
    logic [31:0] cnt_m [3];
    logic [15:0] cnt_addr [3] = '{`SBMV_OFS_P0_DROP, `SBMV_OFS_P1_DROP, `SBMV_OFS_P2_DROP};
    logic [31:0] w;
    logic [31:0] v;
    logic m;

    always #50 core_clk_i = ~core_clk_i;

    sbmv_regs DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .rate_drop_i(rate_drop_i),
        .buffer_irq_pending_i(buffer_irq_pending_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .port1_default_prio_o(p1_prio), .port1_default_vid_o(p1_vid), .port2_default_prio_o(p2_prio),
        .port2_default_vid_o(p2_vid), .buffer_irq_mask_o(mask_o), .buffer_irq_o(irq_o));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
    endtask

    // Answer is fixed at one cycle, so rvalid is sampled at the following falling edge
    task automatic rd(input logic [15:0] a, input logic [2:0] dm, output logic [31:0] d);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        rate_drop_i = dm;
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
        rate_drop_i = 3'h0;
        check(32'(reg_rvalid_o), 32'h1);
        d = reg_rdata_o;
    endtask

    // Drops in the clearing read cycle must survive the clear
    task automatic rdcnt(input int p, input logic [2:0] dm);
        logic [31:0] d;
        rd(cnt_addr[p], dm, d);
        check(d, cnt_m[p]);
        cnt_m[p] = 32'h00000000;
        for (int i = 0; i < 3; i++) if (dm[i]) cnt_m[i] = cnt_m[i] + 32'h1;
    endtask

    function automatic logic [31:0] vlan_exp(input logic [31:0] d);
        return d & 32'h00007FFF;
    endfunction

    function automatic logic [31:0] vlan_rst_exp();
        return 32'({`SBMV_PRIO_RST, `SBMV_VID_RST, `SBMV_PRIO_RST, `SBMV_VID_RST});
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        w = $urandom(61937);
        for (int i = 0; i < 3; i++) cnt_m[i] = 32'h00000000;
        repeat (4) @(negedge core_clk_i);
        srst_i = 1'b0;
        check(32'(mask_o), 32'h1);
        check(32'(irq_o), 32'h0);
        check(32'({p1_prio, p1_vid, p2_prio, p2_vid}), vlan_rst_exp());
        rd(`SBMV_OFS_P1_VLAN, 3'h0, v);
        check(v, 32'h00000001);
        rd(`SBMV_OFS_P2_VLAN, 3'h0, v);
        check(v, 32'h00000001);
        rd(`SBMV_OFS_IRQ_MASK, 3'h0, v);
        check(v, 32'h00000001);
        wr(`SBMV_OFS_P0_DROP, $urandom);
        rd(16'h1C19, 3'h0, v);
        check(v, 32'h00000000);
        for (int i = 0; i < 3; i++) rdcnt(i, 3'h0);
        for (int i = 0; i < 20; i++) begin
            w = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : $urandom;
            wr(i[0] ? `SBMV_OFS_P2_VLAN : `SBMV_OFS_P1_VLAN, w);
            if (i[0]) check(32'({p2_prio, p2_vid}), vlan_exp(w));
            else check(32'({p1_prio, p1_vid}), vlan_exp(w));
            rd(i[0] ? `SBMV_OFS_P2_VLAN : `SBMV_OFS_P1_VLAN, 3'h0, v);
            check(v, vlan_exp(w));
        end
        for (int i = 0; i < 30; i++) begin
            repeat ($urandom_range(40)) begin
                @(negedge core_clk_i);
                rate_drop_i = 3'($urandom);
                for (int k = 0; k < 3; k++) if (rate_drop_i[k]) cnt_m[k] = cnt_m[k] + 32'h1;
            end
            @(negedge core_clk_i);
            rate_drop_i = 3'h0;
            rdcnt($urandom_range(2), 3'($urandom));
        end
        for (int i = 0; i < 12; i++) begin
            m = i[0];
            buffer_irq_pending_i = (i < 2) ? 14'h0000 : 14'($urandom);
            wr(`SBMV_OFS_IRQ_MASK, {31'($urandom), m});
            check(32'(mask_o), 32'(m));
            check(32'(irq_o), 32'(!m && (|buffer_irq_pending_i)));
            buffer_irq_pending_i = 14'h2000 >> i;
            @(negedge core_clk_i);
            check(32'(irq_o), 32'(!m));
            rd(`SBMV_OFS_IRQ_MASK, 3'h0, v);
            check(v, 32'(m));
        end
        // Second reset in mid-run, with the mask open, pending set and drops just counted
        wr(`SBMV_OFS_IRQ_MASK, 32'h00000000);
        rate_drop_i = 3'h7;
        @(negedge core_clk_i);
        check(32'(irq_o), 32'h1);
        rate_drop_i = 3'h0;
        srst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        srst_i = 1'b0;
        for (int i = 0; i < 3; i++) cnt_m[i] = `SBMV_CNT_RST;
        check(32'(mask_o), 32'(`SBMV_MASK_RST));
        check(32'(irq_o), 32'h0);
        check(32'({p1_prio, p1_vid, p2_prio, p2_vid}), vlan_rst_exp());
        for (int i = 0; i < 3; i++) rdcnt(i, 3'h0);
        end_sim();
    end
endmodule
